// ### src/rco_card.v
// RAM card with output ports: bus timing, chip selection and operation decode
`timescale 1ns/10ps
`default_nettype none
`include "rco_defines.vh"

module rco_card #(
   parameter [7:0] CHIP_FITTED = `RCO_FITTED_ALL
) (
   input  wire        core_clk,
   input  wire        reset,
   input  wire        sync,
   input  wire [1:0]  bank_command_line,
   input  wire [3:0]  bus_in,
   output wire [3:0]  bus_out,
   output wire        bus_oe_n,
   output wire [31:0] output_bits
);

   // ==================================================================
   // Decode helpers
   function chip_fitted;
      input [7:0] mask;
      input [2:0] c;
      begin
         chip_fitted = mask[c];
      end
   endfunction

   function op_reads_main;
      input [3:0] op;
      begin
         case (op)
            `RCO_OP_RD_SUB: begin
               op_reads_main = 1'b1;
            end
            `RCO_OP_RD_MAIN: begin
               op_reads_main = 1'b1;
            end
            `RCO_OP_RD_ADD: begin
               op_reads_main = 1'b1;
            end
            default: begin
               op_reads_main = 1'b0;
            end
         endcase
      end
   endfunction

   // Phase decode is only trusted once a sync has fixed the count
   function in_phase;
      input       seen;
      input [2:0] ph;
      input [2:0] want;
      begin
         in_phase = seen && (ph == want);
      end
   endfunction

   // Bank line picks the group of four, the nibble the chip inside it
   function [2:0] chip_of;
      input       upper;
      input [3:0] nib;
      begin
         chip_of = {upper, nib[`RCO_ADR_CHIP_HI:`RCO_ADR_CHIP_LO]};
      end
   endfunction

   function [1:0] reg_of;
      input [3:0] nib;
      begin
         reg_of = nib[`RCO_ADR_REG_HI:`RCO_ADR_REG_LO];
      end
   endfunction

   function op_reads_stat;
      input [3:0] op;
      begin
         op_reads_stat = op[`RCO_OP_DIR_BIT] && op[`RCO_OP_STAT_BIT];
      end
   endfunction

   function op_writes_stat;
      input [3:0] op;
      begin
         op_writes_stat = !op[`RCO_OP_DIR_BIT] && op[`RCO_OP_STAT_BIT];
      end
   endfunction

   function line_for_chip;
      input [1:0] lines;
      input [2:0] c;
      begin
         // Lines 0 and 1 each serve a group of four chips
         line_for_chip = lines[c[2]];
      end
   endfunction

   // ==================================================================
   // Declarations
   reg  [2:0] phase_reg;
   reg  [2:0] phase_next;
   reg        phase_live_reg;
   wire [2:0] phase;
   wire       phase_seen;
   reg  [3:0] rd_sel_data;

   reg  [3:0] op_field_reg;
   reg        src_pend_reg;
   reg  [2:0] chip_reg;
   reg  [1:0] reg_sel_reg;
   reg  [3:0] char_reg;
   reg        sel_valid_reg;
   reg  [3:0] io_op_reg;
   reg        io_live_reg;
   reg  [3:0] bus_out_reg;
   reg        bus_oe_n_reg;

   wire       any_line;
   wire       at_m1;
   wire       at_m2;
   wire       at_x1;
   wire       at_x2;
   wire       at_x3;
   wire       io_take;
   wire       io_write;
   wire       wr_main;
   wire       wr_stat;
   wire       wr_port;
   wire       rd_main_op;
   wire       rd_stat_op;
   wire [3:0] rd_main;
   wire [3:0] rd_stat;
   wire [1:0] stat_idx;

   // ==================================================================
   // Cycle phase tracking; sync marks phase A1
   assign phase = sync ? `RCO_PH_A1 : phase_reg;

   always @* begin
      if (phase == `RCO_PH_X3) begin
         phase_next = `RCO_PH_A1;
      end else begin
         phase_next = phase + 3'h1;
      end
   end

   always @(posedge core_clk) begin
      if (reset) begin
         phase_reg <= `RCO_PH_A1;
         phase_live_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         if (sync) begin
            phase_live_reg <= 1'b1;
         end
      end
   end

   // Nothing is decoded until the first sync has fixed the phase
   assign phase_seen = sync || phase_live_reg;
   assign at_m1 = in_phase(phase_seen, phase, `RCO_PH_M1);
   assign at_m2 = in_phase(phase_seen, phase, `RCO_PH_M2);
   assign at_x1 = in_phase(phase_seen, phase, `RCO_PH_X1);
   assign at_x2 = in_phase(phase_seen, phase, `RCO_PH_X2);
   assign at_x3 = in_phase(phase_seen, phase, `RCO_PH_X3);

   assign any_line = |bank_command_line;

   // ==================================================================
   // Operation field fetch
   always @(posedge core_clk) begin
      if (reset) begin
         op_field_reg <= `RCO_NIBBLE_RST;
      end else if (at_m1) begin
         op_field_reg <= bus_in;
      end
   end

   // ==================================================================
   // Address cycle: chip and register in X2, character in X3
   always @(posedge core_clk) begin
      if (reset) begin
         src_pend_reg <= 1'b0;
         chip_reg <= `RCO_CHIP_RST;
         reg_sel_reg <= `RCO_REG_RST;
         char_reg <= `RCO_NIBBLE_RST;
         sel_valid_reg <= 1'b0;
      end else begin
         src_pend_reg <= 1'b0;
         if (at_x2 && any_line && !io_live_reg) begin
            // Line 1 names the upper group of four chips
            chip_reg <= chip_of(bank_command_line[1], bus_in);
            reg_sel_reg <= reg_of(bus_in);
            src_pend_reg <= 1'b1;
         end
         if (at_x3 && src_pend_reg) begin
            char_reg <= bus_in;
            sel_valid_reg <= 1'b1;
         end
      end
   end

   // ==================================================================
   // Operation capture in M2; the bank in force then decides, since a
   // bank change after the address cycle must deselect the old group
   assign io_take = at_m2 && sel_valid_reg &&
                    line_for_chip(bank_command_line, chip_reg) &&
                    chip_fitted(CHIP_FITTED, chip_reg) &&
                    (op_field_reg == `RCO_OPR_IO);

   always @(posedge core_clk) begin
      if (reset) begin
         io_op_reg <= `RCO_NIBBLE_RST;
         io_live_reg <= 1'b0;
      end else if (io_take) begin
         io_op_reg <= bus_in;
         io_live_reg <= 1'b1;
      end else if (at_x3) begin
         // Dropped at X3 so the next address cycle is not blocked
         io_live_reg <= 1'b0;
      end
   end

   // ==================================================================
   // Operation decode; codes outside this card's set are ignored
   assign io_write = io_live_reg && !io_op_reg[`RCO_OP_DIR_BIT];
   assign wr_main = at_x2 && io_write && (io_op_reg == `RCO_OP_WR_MAIN);
   assign wr_port = at_x2 && io_write && (io_op_reg == `RCO_OP_WR_PORT);
   assign wr_stat = at_x2 && io_live_reg && op_writes_stat(io_op_reg);
   assign rd_main_op = io_live_reg && op_reads_main(io_op_reg);
   assign rd_stat_op = io_live_reg && op_reads_stat(io_op_reg);
   assign stat_idx = io_op_reg[`RCO_OP_STAT_HI:`RCO_OP_STAT_LO];

   // ==================================================================
   // Read driver: data is latched at the end of X1 so the bus sees a
   // flip-flop output for the whole of X2, then released
   // Status reads take the status row, every other read the main row
   always @* begin
      rd_sel_data = rd_main;
      if (rd_stat_op) begin
         rd_sel_data = rd_stat;
      end
   end

   // Idle data is zeroed so a released bus never shows stale characters
   always @(posedge core_clk) begin
      if (reset) begin
         bus_out_reg <= `RCO_NIBBLE_RST;
         bus_oe_n_reg <= 1'b1;
      end else if (at_x1 && (rd_main_op || rd_stat_op)) begin
         bus_out_reg <= rd_sel_data;
         bus_oe_n_reg <= 1'b0;
      end else if (at_x2) begin
         bus_out_reg <= `RCO_NIBBLE_RST;
         bus_oe_n_reg <= 1'b1;
      end
   end

   assign bus_out = bus_out_reg;
   assign bus_oe_n = bus_oe_n_reg;

   // ==================================================================
   // Storage and output ports
   // Both storages share one selection; only their row decoders differ
   rco_store u_store (
      .core_clk  (core_clk),
      .reset     (reset),
      .wr_main   (wr_main),
      .wr_stat   (wr_stat),
      .chip      (chip_reg),
      .reg_sel   (reg_sel_reg),
      .char_addr (char_reg),
      .stat_idx  (stat_idx),
      .wr_data   (bus_in),
      .rd_main   (rd_main),
      .rd_stat   (rd_stat)
   );

   // Port data comes straight off the bus in X2, with no extra stage
   rco_port u_port (
      .core_clk    (core_clk),
      .reset       (reset),
      .wr_en       (wr_port),
      .chip        (chip_reg),
      .wr_data     (bus_in),
      .output_bits (output_bits)
   );

endmodule
`default_nettype wire

// ### src/rco_defines.vh
// Constants shared by the RAM card with output ports
`ifndef RCO_DEFINES_VH
`define RCO_DEFINES_VH

// ==================================================================
// Instruction cycle phases, one clock each, eight to a cycle
`define RCO_PH_A1        3'h0
`define RCO_PH_A2        3'h1
`define RCO_PH_A3        3'h2
`define RCO_PH_M1        3'h3
`define RCO_PH_M2        3'h4
`define RCO_PH_X1        3'h5
`define RCO_PH_X2        3'h6
`define RCO_PH_X3        3'h7

// ==================================================================
// Operation field of the I/O and memory instruction group
`define RCO_OPR_IO       4'hE

// Modifier codes of the I/O and memory group
`define RCO_OP_WR_MAIN   4'h0
`define RCO_OP_WR_PORT   4'h1
`define RCO_OP_RD_SUB    4'h8
`define RCO_OP_RD_MAIN   4'h9
`define RCO_OP_RD_ADD    4'hB

// Field positions inside the modifier
`define RCO_OP_DIR_BIT   3
`define RCO_OP_STAT_BIT  2
`define RCO_OP_STAT_HI   1
`define RCO_OP_STAT_LO   0

// Field positions inside the first address nibble
`define RCO_ADR_CHIP_HI  3
`define RCO_ADR_CHIP_LO  2
`define RCO_ADR_REG_HI   1
`define RCO_ADR_REG_LO   0

// ==================================================================
// Storage sizes: 8 chips x 4 registers x 16 main / 4 status chars
`define RCO_MAIN_WORDS   512
`define RCO_STAT_WORDS   128

// ==================================================================
// Reset values
`define RCO_NIBBLE_RST   4'h0
`define RCO_CHIP_RST     3'h0
`define RCO_REG_RST      2'h0
`define RCO_PORT_RST     32'h0000_0000
`define RCO_FITTED_ALL   8'hFF

`endif

// ### src/rco_store.v
// Character storage of all eight memory chips with separate row decoders
`timescale 1ns/10ps
`default_nettype none
`include "rco_defines.vh"

module rco_store (
   input  wire       core_clk,
   input  wire       reset,
   input  wire       wr_main,
   input  wire       wr_stat,
   input  wire [2:0] chip,
   input  wire [1:0] reg_sel,
   input  wire [3:0] char_addr,
   input  wire [1:0] stat_idx,
   input  wire [3:0] wr_data,
   output wire [3:0] rd_main,
   output wire [3:0] rd_stat
);

   reg [3:0] main_mem [0:`RCO_MAIN_WORDS-1];
   reg [3:0] stat_mem [0:`RCO_STAT_WORDS-1];
   integer   i;

   // ==================================================================
   // Row decoders, one per storage kind
   function [8:0] main_row;
      input [2:0] c;
      input [1:0] r;
      input [3:0] ch;
      begin
         main_row = {c, r, ch};
      end
   endfunction

   function [6:0] stat_row;
      input [2:0] c;
      input [1:0] r;
      input [1:0] s;
      begin
         stat_row = {c, r, s};
      end
   endfunction

   // ==================================================================
   // Storage; reset wipes every character as the processor reset does
   always @(posedge core_clk) begin
      if (reset) begin
         for (i = 0; i < `RCO_MAIN_WORDS; i = i + 1) begin
            main_mem[i] <= `RCO_NIBBLE_RST;
         end
         for (i = 0; i < `RCO_STAT_WORDS; i = i + 1) begin
            stat_mem[i] <= `RCO_NIBBLE_RST;
         end
      end else begin
         if (wr_main) begin
            main_mem[main_row(chip, reg_sel, char_addr)] <= wr_data;
         end
         if (wr_stat) begin
            stat_mem[stat_row(chip, reg_sel, stat_idx)] <= wr_data;
         end
      end
   end

   assign rd_main = main_mem[main_row(chip, reg_sel, char_addr)];
   assign rd_stat = stat_mem[stat_row(chip, reg_sel, stat_idx)];

endmodule
`default_nettype wire

// ### src/rco_port.v
// Latched 4-bit output ports, one per memory chip
`timescale 1ns/10ps
`default_nettype none
`include "rco_defines.vh"

module rco_port (
   input  wire        core_clk,
   input  wire        reset,
   input  wire        wr_en,
   input  wire [2:0]  chip,
   input  wire [3:0]  wr_data,
   output wire [31:0] output_bits
);

   reg [31:0] port_reg;

   // ==================================================================
   // Each nibble holds until the next port write to the same chip
   always @(posedge core_clk) begin
      if (reset) begin
         port_reg <= `RCO_PORT_RST;
      end else if (wr_en) begin
         port_reg[{chip, 2'b00} +: 4] <= wr_data;
      end
   end

   assign output_bits = port_reg;

endmodule
`default_nettype wire

// ### tb/rco_card_asserts.sv
// Concurrent checks on the ports of the RAM card
`timescale 1ns/10ps
`default_nettype none
`include "rco_defines.vh"

module rco_card_asserts (
   input wire logic        core_clk,
   input wire logic        reset,
   input wire logic        sync,
   input wire logic [1:0]  bank_command_line,
   input wire logic [3:0]  bus_in,
   input wire logic [3:0]  bus_out,
   input wire logic        bus_oe_n,
   input wire logic [31:0] output_bits
);
   // ==============================================================
   // Phase tracking, realigned by every sync
   logic [2:0] ph_reg;
   logic [2:0] ph_now;
   assign ph_now = sync ? `RCO_PH_A1 : ph_reg;
   always_ff @(posedge core_clk) begin
      ph_reg <= reset ? 3'h0 : ph_now + 3'h1;
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (reset);

   // ==============================================================
   // Properties
   property p_oe_one;    $fell(bus_oe_n) |=> bus_oe_n; endproperty
   property p_oe_phase;  !bus_oe_n |-> ph_now == `RCO_PH_X2; endproperty
   property p_out_zero;  bus_oe_n |-> bus_out == 4'h0; endproperty
   property p_port_x3;
      !$past(reset) && $changed(output_bits) |-> ph_now == `RCO_PH_X3;
   endproperty
   // Port data lands at the edge ending X2, so the op codes sit three and four edges back
   property p_port_op;
      !$past(reset) && $changed(output_bits) |->
         $past(bus_in, 3) == `RCO_OP_WR_PORT && $past(bus_in, 4) == `RCO_OPR_IO;
   endproperty
   property p_rd_op;
      $fell(bus_oe_n) |-> $past(bus_in[3], 2) && $past(bus_in, 2) != 4'hA
         && $past(bus_in, 3) == `RCO_OPR_IO;
   endproperty
   property p_rd_bank;   $fell(bus_oe_n) |-> $past(bank_command_line, 2) != 2'b00; endproperty
   property p_reset_clr; $past(reset) |-> bus_oe_n && output_bits == 32'h0; endproperty

   a_oe_one:    assert property (p_oe_one)    else $error("bus drive longer than one cycle");
   a_oe_phase:  assert property (p_oe_phase)  else $error("bus driven outside X2");
   a_out_zero:  assert property (p_out_zero)  else $error("bus_out not zero when idle");
   a_port_x3:   assert property (p_port_x3)   else $error("port changed at wrong phase");
   a_port_op:   assert property (p_port_op)   else $error("port changed without port write");
   a_rd_op:     assert property (p_rd_op)     else $error("bus driven without read code");
   a_rd_bank:   assert property (p_rd_bank)   else $error("read without bank line in M2");
   a_reset_clr: assert property (p_reset_clr) else $error("outputs not cleared by reset");

   c_read: cover property ($fell(bus_oe_n));
   c_port: cover property (!$past(reset) && $changed(output_bits));
   c_data: cover property (!bus_oe_n && bus_out != 4'h0);
endmodule

bind rco_card rco_card_asserts u_chk (
   .core_clk(core_clk), .reset(reset), .sync(sync), .bank_command_line(bank_command_line),
   .bus_in(bus_in), .bus_out(bus_out), .bus_oe_n(bus_oe_n), .output_bits(output_bits));
`default_nettype wire

// ### tb/rco_cpu.sv
// Behavioural processor driving the card's bus, sync and bank lines
`timescale 1ns/10ps
`default_nettype none

module rco_cpu (
   input wire logic   core_clk,
   input wire logic   [3:0] bus_out,
   input wire logic   bus_oe_n,
   output logic       sync,
   output logic [1:0] bank_command_line,
   output logic [3:0] bus_in
);
   logic [2:0] bank_code = 3'h0;
   initial begin
      sync = 1'b0;
      bank_command_line = 2'b00;
      bus_in = 4'h5;
   end

   // New code only shows on lines from the next instruction onward
   task automatic designate(input logic [2:0] code);
      bank_code = code;
   endtask

   task automatic instr(input logic [3:0] operation_field, input logic [3:0] modifier_field, input logic src,
                        input logic [3:0] x2v, input logic [3:0] x3v,
                        output logic [3:0] rd, output int drv);
      logic [1:0] lines;
      lines = (bank_code == 3'h0) ? 2'b01 : 2'b10;
      drv = 0;
      rd = 4'h0;
      for (int ph = 0; ph < 8; ph++) begin
         @(negedge core_clk);
         if (bus_oe_n === 1'b0) begin
            drv++;
            rd = bus_out;
         end
         sync = (ph == 0);
         bank_command_line = ((ph == 4 && !src) || (ph == 6 && src)) ? lines : 2'b00;
         // Undriven phases show a changing value so stale data cannot pass
         bus_in = (ph == 3) ? operation_field : (ph == 4) ? modifier_field : (ph == 6) ? x2v :
                  (ph == 7 && src) ? x3v : ~bus_in;
      end
   endtask
endmodule
`default_nettype wire

// ### tb/rco_card_test.sv
// Self-checking bench for the RAM card with output ports
`timescale 1ns/10ps
`default_nettype none
`include "rco_defines.vh"
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin errors++; \
   $display("ERROR %s expected %h seen %h", nm, exp, got); end end

module rco_card_test;
   logic        core_clk = 1'b0;
   logic        reset = 1'b1;
   wire         sync;
   wire  [1:0]  bank_command_line;
   wire  [3:0]  bus_in;
   wire  [3:0]  bus_out;
   wire         bus_oe_n;
   wire  [31:0] output_bits;
   int          errors = 0;
   int          compares = 0;
   int          cycles = 0;
   logic [31:0] exp_ports = 32'h0;

   always #2.5 core_clk = ~core_clk;

   // Chip 7 left out so that the unfitted path is reached
   rco_card #(.CHIP_FITTED(8'h7F)) uut (.core_clk(core_clk), .reset(reset), .sync(sync),
      .bank_command_line(bank_command_line), .bus_in(bus_in), .bus_out(bus_out),
      .bus_oe_n(bus_oe_n), .output_bits(output_bits));
   rco_cpu cpu (.core_clk(core_clk), .bus_out(bus_out), .bus_oe_n(bus_oe_n), .sync(sync),
      .bank_command_line(bank_command_line), .bus_in(bus_in));

   task automatic tally_and_finish;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         tally_and_finish;
      end
   end

   task automatic src(input logic [2:0] c, input logic [1:0] r, input logic [3:0] ch);
      logic [3:0] rd;
      int d;
      cpu.designate({2'b00, c[2]});
      cpu.instr(4'h2, 4'h1, 1'b1, {c[1:0], r}, ch, rd, d);
   endtask

   task automatic io(input logic [3:0] op, input logic [3:0] wd, input int drv,
                     input logic [3:0] er);
      logic [3:0] rd;
      int d;
      cpu.instr(`RCO_OPR_IO, op, 1'b0, wd, 4'h0, rd, d);
      `CHK("bus_drive_cycles", drv, d)
      if (drv == 1) `CHK("read_data", er, rd)
      `CHK("output_bits", exp_ports, output_bits)
   endtask

   task automatic t_reset;
      `CHK("ports_reset", 32'h0, output_bits)
      `CHK("oe_reset", 1'b1, bus_oe_n)
      $display("test reset done");
   endtask

   task automatic t_main;
      logic [11:0] rdm = 12'hB98;
      src(3'h5, 2'h2, 4'hF);
      io(`RCO_OP_WR_MAIN, 4'hA, 0, 4'h0);
      src(3'h5, 2'h2, 4'h0);
      io(`RCO_OP_WR_MAIN, 4'h3, 0, 4'h0);
      src(3'h5, 2'h2, 4'hF);
      io(`RCO_OP_RD_MAIN, 4'h0, 1, 4'hA);
      src(3'h5, 2'h3, 4'hF);
      io(`RCO_OP_RD_MAIN, 4'h0, 1, 4'h0);
      src(3'h1, 2'h2, 4'hF);
      io(`RCO_OP_RD_MAIN, 4'h0, 1, 4'h0);
      src(3'h5, 2'h2, 4'h0);
      for (int i = 0; i < 3; i++) io(rdm[4*i +: 4], 4'h0, 1, 4'h3);
      $display("test main done");
   endtask

   task automatic t_status;
      src(3'h5, 2'h2, 4'h0);
      for (int i = 0; i < 4; i++) io(4'h4 + i[3:0], 4'h8 + i[3:0], 0, 4'h0);
      src(3'h5, 2'h2, 4'h7);
      for (int i = 0; i < 4; i++) io(4'hC + i[3:0], 4'h0, 1, 4'h8 + i[3:0]);
      src(3'h5, 2'h2, 4'h0);
      io(`RCO_OP_RD_MAIN, 4'h0, 1, 4'h3);
      $display("test status done");
   endtask

   task automatic t_port;
      src(3'h2, 2'h0, 4'h0);
      exp_ports = 32'h0000_0D00;
      io(`RCO_OP_WR_PORT, 4'hD, 0, 4'h0);
      src(3'h6, 2'h1, 4'h3);
      exp_ports = 32'h0600_0D00;
      io(`RCO_OP_WR_PORT, 4'h6, 0, 4'h0);
      io(`RCO_OP_WR_MAIN, 4'h9, 0, 4'h0);
      io(`RCO_OP_RD_MAIN, 4'h0, 1, 4'h9);
      $display("test port done");
   endtask

   task automatic t_refuse;
      logic [3:0] rd;
      int d;
      src(3'h7, 2'h0, 4'h0);
      io(`RCO_OP_WR_PORT, 4'hF, 0, 4'h0);
      io(`RCO_OP_RD_MAIN, 4'h0, 0, 4'h0);
      src(3'h6, 2'h1, 4'h3);
      io(4'h2, 4'hF, 0, 4'h0);
      io(4'hA, 4'hF, 0, 4'h0);
      cpu.instr(4'hD, `RCO_OP_WR_PORT, 1'b0, 4'hF, 4'h0, rd, d);
      `CHK("ports_bad_opr", exp_ports, output_bits)
      cpu.designate(3'h0);
      io(`RCO_OP_RD_MAIN, 4'h0, 0, 4'h0);
      io(`RCO_OP_WR_PORT, 4'hF, 0, 4'h0);
      $display("test refuse done");
   endtask

   initial begin
      repeat (10) @(negedge core_clk);
      reset = 1'b0;
      t_reset;
      t_main;
      t_status;
      t_port;
      t_refuse;
      tally_and_finish;
   end
endmodule
`default_nettype wire
